// File: rtl/cvseq_consts.svh
/*
  Constants of the conversion cycle sequencer: timing, register offsets,
  field positions and codes.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CVSEQ_CONSTS_SVH
`define CVSEQ_CONSTS_SVH

// ============================================================
// Timing
`define CVSEQ_CLK_MHZ 125
`define CVSEQ_MAX2_US 167200
`define CVSEQ_MAX3_US 251000
`define CVSEQ_CYCLE_US (`CVSEQ_MAX2_US / 2)
`define CVSEQ_OC_PULSE_US 8000
`define CVSEQ_CYCLE_CLKS (`CVSEQ_CYCLE_US * `CVSEQ_CLK_MHZ)
`define CVSEQ_OC_PULSE_CLKS (`CVSEQ_OC_PULSE_US * `CVSEQ_CLK_MHZ)

// ============================================================
// Register byte offsets
`define CVSEQ_OFS_CONTROL 8'h00
`define CVSEQ_OFS_CONFIG 8'h04
`define CVSEQ_OFS_STATUS 8'h08
`define CVSEQ_OFS_RESULT 8'h0c
`define CVSEQ_OFS_CHAN_WORD 8'h10
`define CVSEQ_OFS_TABLE_INFO 8'h14
`define CVSEQ_OFS_IRQ_STATUS 8'h18
`define CVSEQ_OFS_IRQ_MASK 8'h1c

// ============================================================
// Config fields
`define CVSEQ_CFG_TYPE_LSB 0
`define CVSEQ_CFG_TYPE_MSB 1
`define CVSEQ_CFG_OC_BIT 2
`define CVSEQ_CFG_AUTO_BIT 3
`define CVSEQ_CFG_THREE_BIT 4
`define CVSEQ_CFG_CJ3_BIT 5
`define CVSEQ_CFG_W 6
`define CVSEQ_CTRL_START_BIT 0

// ============================================================
// Channel assignment word fields
`define CVSEQ_CW_TYPE_MSB 31
`define CVSEQ_CW_TYPE_LSB 27
`define CVSEQ_CW_SD_BIT 26
`define CVSEQ_CW_TBL_BIT 25
`define CVSEQ_CW_ZERO_MSB 24
`define CVSEQ_CW_ZERO_LSB 12
`define CVSEQ_CW_PTR_MSB 11
`define CVSEQ_CW_PTR_LSB 6
`define CVSEQ_CW_LEN_MSB 5
`define CVSEQ_CW_LEN_LSB 0
`define CVSEQ_ADC_TYPE_CODE 5'h1e
`define CVSEQ_CW_ZERO_VAL 13'h0000
`define CVSEQ_TABLE_BASE 12'h250
`define CVSEQ_TABLE_ENTRY_BYTES 12'h006

// ============================================================
// Interrupt bits, cycle counts, result width
`define CVSEQ_IRQ_DONE 0
`define CVSEQ_IRQ_FAULT 1
`define CVSEQ_IRQ_W 2
`define CVSEQ_TWO_CYCLES 2'h2
`define CVSEQ_THREE_CYCLES 2'h3
`define CVSEQ_RESULT_W 24

`endif

// File: rtl/cvseq_pkg.sv
/*
  Types of the conversion cycle sequencer.
  Assumes cvseq_consts.svh is on the include path.
*/
`include "cvseq_consts.svh"

package cvseq_pkg;

  // ============================================================
  // Enumerations
  typedef enum logic [1:0] {
    CVSEQ_THERMOCOUPLE,
    CVSEQ_RTD,
    CVSEQ_THERMISTOR,
    CVSEQ_DIODE
  } cvseq_sensor_t;

  typedef enum logic [1:0] {
    CVSEQ_IDLE,
    CVSEQ_OC_PULSE,
    CVSEQ_OC_SETTLE,
    CVSEQ_CYCLE
  } cvseq_state_t;

  typedef logic signed [`CVSEQ_RESULT_W-1:0] cvseq_result_t;

endpackage : cvseq_pkg

// File: rtl/cvseq_tmr_if.sv
/*
  Carrier between the sequencer and its interval timer.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps

interface cvseq_tmr_if;
  logic load;
  logic [31:0] count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : cvseq_tmr_if

// File: rtl/cvseq_timer.sv
/*
  Interval timer: after a load of N, expired stands in the cycle ending at the Nth edge.
  Assumes N is at least one; a new load restarts the interval.
*/
`timescale 1ns/10ps

module cvseq_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  cvseq_tmr_if.tmr tmr
);
  import cvseq_pkg::*;

  typedef struct packed {
    logic [31:0] remaining;
    logic running;
  } cvseq_tmr_regs_t;

  cvseq_tmr_regs_t r;
  cvseq_tmr_regs_t next_r;

  // ============================================================
  // Counting
  always_comb begin
    next_r = r;
    if (tmr.load) begin
      next_r.remaining = tmr.count;
      next_r.running = 1'b1;
    end else if (r.running) begin
      if (r.remaining == 32'h0000_0001) begin
        next_r.running = 1'b0;
      end
      next_r.remaining = r.remaining - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Combinational, so the user acts exactly N edges after its load edge
  assign tmr.expired = r.running && (r.remaining == 32'h0000_0001);

endmodule : cvseq_timer

// File: rtl/cvseq_top.sv
/*
  Conversion cycle sequencer with Avalon-MM register slave.
  Assumes the front end supplies a range code and a conversion result
  on this clock, and an asynchronous open-circuit sense pin.
*/
// Functional notes
// - A standard result takes exactly two cycles, finishing within 167.2 ms.
// - Two cycles cancel offset, drift, low-frequency noise, calibrate current sources.
// - A three-cycle result finishes within 251 ms with all two-cycle benefits.
// - Cycle count per result follows sensor type and configuration: two or three.
// - Thermocouple without open-circuit or three-cycle cold-junction select: two cycles, no test current applied.
// - Open-circuit select: 8 ms test pulse, settle to the end of that first cycle, then two cycles.
// - A broken thermocouple during the test pulse reports an open-circuit fault.
// - Autoranged thermistor: first cycle picks current, next two measure with it.
// - Three-reading diode: three ratioed currents over three cycles.
// - Thermocouple with three-cycle cold-junction sensor is ready after three cycles.
// - Table lookup word: type 11110, single/diff, table bit, 13 zeros, pointer, length.
// - Table results are signed 24-bit two's complement integers.
`timescale 1ns/10ps
`include "cvseq_consts.svh"

module cvseq_top #(
  parameter int unsigned CYCLE_CLKS = `CVSEQ_CYCLE_CLKS,
  parameter int unsigned OC_PULSE_CLKS = `CVSEQ_OC_PULSE_CLKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interrupt
  output logic irq_o,
  // Front end
  input wire logic open_sense_i,
  input wire logic [2:0] range_code_i,
  input wire cvseq_pkg::cvseq_result_t adc_result_i,
  output logic cycle_start_o,
  output logic [1:0] cycle_index_o,
  output logic test_current_o,
  output logic autorange_test_o,
  output logic [2:0] excite_range_o,
  output logic [1:0] current_ratio_o,
  output logic busy_o
);
  import cvseq_pkg::*;

  typedef struct packed {
    cvseq_state_t state;
    logic [1:0] cyc_idx;
    logic [1:0] cyc_total;
    logic ack;
    logic [31:0] rdata;
    logic [`CVSEQ_CFG_W-1:0] cfg;
    logic [31:0] chan_word;
    logic table_mode;
    cvseq_result_t result;
    logic done;
    logic fault;
    logic [`CVSEQ_IRQ_W-1:0] irq_stat;
    logic [`CVSEQ_IRQ_W-1:0] irq_mask;
    logic [2:0] range;
    logic oc_pulse;
    logic cyc_strobe;
    logic sync_meta;
    logic sync_oc;
  } cvseq_regs_t;

  cvseq_regs_t r;
  cvseq_regs_t next_r;

  cvseq_tmr_if tmr_bus ();

  cvseq_timer u_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tmr(tmr_bus.tmr)
  );

  // ============================================================
  // Decode of configuration and channel word
  cvseq_sensor_t sensor;
  logic word_valid;
  logic [5:0] tbl_ptr;
  logic [5:0] tbl_len;
  logic [11:0] tbl_addr;
  logic [1:0] start_total;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic start_req;
  logic [`CVSEQ_IRQ_W-1:0] irq_set;
  logic [31:0] rd_mux;

  assign sensor = cvseq_sensor_t'(r.cfg[`CVSEQ_CFG_TYPE_MSB:`CVSEQ_CFG_TYPE_LSB]);
  // Word is taken as table lookup only when every fixed field matches
  assign word_valid = (r.chan_word[`CVSEQ_CW_TYPE_MSB:`CVSEQ_CW_TYPE_LSB] ==
                       `CVSEQ_ADC_TYPE_CODE) &&
                      r.chan_word[`CVSEQ_CW_TBL_BIT] &&
                      (r.chan_word[`CVSEQ_CW_ZERO_MSB:`CVSEQ_CW_ZERO_LSB] ==
                       `CVSEQ_CW_ZERO_VAL);
  assign tbl_ptr = r.chan_word[`CVSEQ_CW_PTR_MSB:`CVSEQ_CW_PTR_LSB];
  assign tbl_len = r.chan_word[`CVSEQ_CW_LEN_MSB:`CVSEQ_CW_LEN_LSB];
  // Pointer counts six-byte entries from the table base
  assign tbl_addr = `CVSEQ_TABLE_BASE +
                    12'(tbl_ptr) * `CVSEQ_TABLE_ENTRY_BYTES;

  // ============================================================
  // Cycle count selection
  always_comb begin
    start_total = `CVSEQ_TWO_CYCLES;
    if (!word_valid) begin
      case (sensor)
        CVSEQ_THERMOCOUPLE: begin
          if (r.cfg[`CVSEQ_CFG_OC_BIT] || r.cfg[`CVSEQ_CFG_CJ3_BIT]) begin
            start_total = `CVSEQ_THREE_CYCLES;
          end
        end
        CVSEQ_THERMISTOR: begin
          if (r.cfg[`CVSEQ_CFG_AUTO_BIT]) begin
            start_total = `CVSEQ_THREE_CYCLES;
          end
        end
        CVSEQ_DIODE: begin
          if (r.cfg[`CVSEQ_CFG_THREE_BIT]) begin
            start_total = `CVSEQ_THREE_CYCLES;
          end
        end
        default: begin
          start_total = `CVSEQ_TWO_CYCLES;
        end
      endcase
    end
  end

  // ============================================================
  // Bus access
  assign bus_req = (avs_read_i || avs_write_i) && !r.ack;
  assign bus_wr = avs_write_i && r.ack;
  assign bus_rd = avs_read_i && r.ack;
  assign start_req = bus_wr && (avs_address_i == `CVSEQ_OFS_CONTROL) &&
                     avs_writedata_i[`CVSEQ_CTRL_START_BIT] &&
                     (r.state == CVSEQ_IDLE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `CVSEQ_OFS_CONTROL: rd_mux = 32'h0000_0000;
      `CVSEQ_OFS_CONFIG: rd_mux = 32'(r.cfg);
      `CVSEQ_OFS_STATUS: rd_mux = {25'h000_0000, r.cyc_total, r.table_mode,
                                   word_valid, r.fault, r.done,
                                   (r.state != CVSEQ_IDLE)};
      // Sign extended so software reads a plain signed word
      `CVSEQ_OFS_RESULT: rd_mux = 32'(signed'(r.result));
      `CVSEQ_OFS_CHAN_WORD: rd_mux = r.chan_word;
      `CVSEQ_OFS_TABLE_INFO: rd_mux = {r.chan_word[`CVSEQ_CW_SD_BIT], 7'h00,
                                       tbl_addr, tbl_ptr, tbl_len};
      `CVSEQ_OFS_IRQ_STATUS: rd_mux = 32'(r.irq_stat);
      `CVSEQ_OFS_IRQ_MASK: rd_mux = 32'(r.irq_mask);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ============================================================
  // Sequencer and register file
  always_comb begin
    next_r = r;
    irq_set = '0;
    tmr_bus.load = 1'b0;
    tmr_bus.count = CYCLE_CLKS;
    next_r.cyc_strobe = 1'b0;
    next_r.sync_meta = open_sense_i;
    next_r.sync_oc = r.sync_meta;
    next_r.ack = bus_req;
    if (bus_req) begin
      next_r.rdata = rd_mux;
    end
    // Configuration is frozen while a result is in progress
    if (bus_wr && (r.state == CVSEQ_IDLE)) begin
      case (avs_address_i)
        `CVSEQ_OFS_CONFIG: next_r.cfg = avs_writedata_i[`CVSEQ_CFG_W-1:0];
        `CVSEQ_OFS_CHAN_WORD: next_r.chan_word = avs_writedata_i;
        default: begin
        end
      endcase
    end
    if (bus_wr && (avs_address_i == `CVSEQ_OFS_IRQ_MASK)) begin
      next_r.irq_mask = avs_writedata_i[`CVSEQ_IRQ_W-1:0];
    end
    case (r.state)
      CVSEQ_IDLE: begin
        if (start_req) begin
          next_r.done = 1'b0;
          next_r.fault = 1'b0;
          next_r.cyc_idx = 2'h0;
          next_r.cyc_total = start_total;
          next_r.table_mode = word_valid;
          tmr_bus.load = 1'b1;
          if (!word_valid && (sensor == CVSEQ_THERMOCOUPLE) &&
              r.cfg[`CVSEQ_CFG_OC_BIT]) begin
            next_r.state = CVSEQ_OC_PULSE;
            next_r.oc_pulse = 1'b1;
            tmr_bus.count = OC_PULSE_CLKS;
          end else begin
            next_r.state = CVSEQ_CYCLE;
            next_r.cyc_strobe = 1'b1;
          end
        end
      end
      CVSEQ_OC_PULSE: begin
        if (tmr_bus.expired) begin
          next_r.oc_pulse = 1'b0;
          // Open wire lets the pulse pull the sense line high
          next_r.fault = r.sync_oc;
          next_r.state = CVSEQ_OC_SETTLE;
          tmr_bus.load = 1'b1;
          tmr_bus.count = CYCLE_CLKS - OC_PULSE_CLKS;
        end
      end
      CVSEQ_OC_SETTLE: begin
        if (tmr_bus.expired) begin
          next_r.state = CVSEQ_CYCLE;
          next_r.cyc_idx = 2'h1;
          next_r.cyc_strobe = 1'b1;
          tmr_bus.load = 1'b1;
        end
      end
      CVSEQ_CYCLE: begin
        if (tmr_bus.expired) begin
          if ((r.cyc_idx == 2'h0) && (sensor == CVSEQ_THERMISTOR) &&
              r.cfg[`CVSEQ_CFG_AUTO_BIT] && !r.table_mode) begin
            next_r.range = range_code_i;
          end
          if (r.cyc_idx == r.cyc_total - 2'h1) begin
            next_r.state = CVSEQ_IDLE;
            next_r.done = 1'b1;
            next_r.result = adc_result_i;
            irq_set[`CVSEQ_IRQ_DONE] = 1'b1;
            irq_set[`CVSEQ_IRQ_FAULT] = r.fault;
          end else begin
            next_r.cyc_idx = r.cyc_idx + 2'h1;
            next_r.cyc_strobe = 1'b1;
            tmr_bus.load = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = CVSEQ_IDLE;
      end
    endcase
    // New events win over the clear-on-read
    if (bus_rd && (avs_address_i == `CVSEQ_OFS_IRQ_STATUS)) begin
      next_r.irq_stat = irq_set;
    end else begin
      next_r.irq_stat = r.irq_stat | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ============================================================
  // Outputs
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !r.ack;
  assign avs_readdata_o = r.rdata;
  assign irq_o = |(r.irq_stat & r.irq_mask);
  assign cycle_start_o = r.cyc_strobe;
  assign cycle_index_o = r.cyc_idx;
  assign test_current_o = r.oc_pulse;
  assign busy_o = (r.state != CVSEQ_IDLE);
  assign autorange_test_o = (r.state == CVSEQ_CYCLE) && (r.cyc_idx == 2'h0) &&
                            (sensor == CVSEQ_THERMISTOR) && !r.table_mode &&
                            r.cfg[`CVSEQ_CFG_AUTO_BIT];
  assign excite_range_o = r.range;
  // Ratio code 1..3 steps per cycle only in three-reading diode mode
  assign current_ratio_o = ((r.state == CVSEQ_CYCLE) && (sensor == CVSEQ_DIODE) &&
                            !r.table_mode && r.cfg[`CVSEQ_CFG_THREE_BIT]) ?
                           (r.cyc_idx + 2'h1) : 2'h0;

endmodule : cvseq_top

// File: rtl/_unused.sv
`timescale 1ns/10ps

// File: bench/cvseq_sensor_model.sv
/*
  Model of the sensors behind the sequencer's excitation outputs.
  Assumes the bench sets broken, range and value per scenario.
*/
`timescale 1ns/10ps

module cvseq_sensor_model (
  // Excitation from the sequencer
  input wire logic test_current_i,
  input wire logic autorange_test_i,
  // Scenario settings
  input wire logic broken_i,
  input wire logic [2:0] range_i,
  input wire logic [23:0] value_i,
  // Sensed values
  output logic open_sense_o,
  output logic [2:0] range_code_o,
  output logic [23:0] adc_result_o
);
  // ============================================================
  // Sensing
  // Only the test current can lift a broken input
  assign open_sense_o = broken_i & test_current_i;
  // Range reading is garbage outside the test cycle
  assign range_code_o = autorange_test_i ? range_i : ~range_i;
  assign adc_result_o = value_i;
endmodule : cvseq_sensor_model

// File: bench/cvseq_chk.sv
/*
  Concurrent checks on the sequencer's top ports.
  Assumes one clock and the synchronous active low reset.
*/
`timescale 1ns/10ps

module cvseq_chk #(
  parameter int unsigned CYCLE_CLKS = 20,
  parameter int unsigned OC_PULSE_CLKS = 5
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_waitrequest_o,
  input wire logic cycle_start_o,
  input wire logic [1:0] cycle_index_o,
  input wire logic test_current_o,
  input wire logic autorange_test_o,
  input wire logic [1:0] current_ratio_o,
  input wire logic busy_o
);
  // ============================================================
  // Helper counters
  int unsigned bz_cnt;
  int unsigned tc_cnt;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bz_cnt <= 0;
      tc_cnt <= 0;
    end else begin
      bz_cnt <= busy_o ? bz_cnt + 1 : 0;
      tc_cnt <= test_current_o ? tc_cnt + 1 : 0;
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_start_in_busy: assert property (cycle_start_o |-> busy_o)
    else $error("cycle start outside a result");
  a_cycle_gap: assert property (cycle_start_o |=> !cycle_start_o [*8])
    else $error("cycle starts too close");
  a_index_range: assert property (busy_o |-> cycle_index_o <= 2'h2)
    else $error("cycle index beyond three cycles");
  a_pulse_len: assert property ($fell(test_current_o) |-> tc_cnt == OC_PULSE_CLKS)
    else $error("test pulse length wrong");
  a_test_first: assert property (test_current_o |-> busy_o && cycle_index_o == 2'h0)
    else $error("test current outside first cycle");
  a_range_first: assert property (autorange_test_o |-> busy_o && cycle_index_o == 2'h0)
    else $error("range test outside first cycle");
  a_ratio_step: assert property (current_ratio_o != 2'h0 |->
    current_ratio_o == cycle_index_o + 2'h1)
    else $error("current ratio does not follow cycle");
  a_busy_span: assert property ($fell(busy_o) |->
    bz_cnt >= 2 * CYCLE_CLKS - 1 && bz_cnt <= 3 * CYCLE_CLKS + 1)
    else $error("result time out of range");
  a_wait_state: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait state wrong");
endmodule : cvseq_chk

bind cvseq_top cvseq_chk #(.CYCLE_CLKS(CYCLE_CLKS), .OC_PULSE_CLKS(OC_PULSE_CLKS)) u_chk (
  .clk_i, .resetn_i, .avs_read_i, .avs_waitrequest_o, .cycle_start_o, .cycle_index_o,
  .test_current_o, .autorange_test_o, .current_ratio_o, .busy_o);

// File: bench/cvseq_tb_top.sv
/*
  Self-checking bench: register tasks drive the sequencer through every mode.
  Assumes short cycle parameters; the sensor model sits on the front end.
*/
`timescale 1ns/10ps

module cvseq_tb_top;
  import cvseq_pkg::*;
  localparam int CC = 20;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic avs_waitrequest_o, irq_o, open_sense_i, cycle_start_o, test_current_o;
  logic autorange_test_o, busy_o, seen_tc, seen_ar;
  logic [2:0] range_code_i, excite_range_o;
  logic [1:0] cycle_index_o, current_ratio_o, max_ratio;
  cvseq_result_t adc_result_i;
  int n_fail = 0, cmp_count = 0, busy_cnt, nc;
  logic [5:0] cfgs [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h20, 6'h0a, 6'h13};

  always #4 clk_i = ~clk_i;

  cvseq_top #(.CYCLE_CLKS(CC), .OC_PULSE_CLKS(5)) dut (.clk_i, .resetn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .irq_o, .open_sense_i, .range_code_i, .adc_result_i, .cycle_start_o, .cycle_index_o,
    .test_current_o, .autorange_test_o, .excite_range_o, .current_ratio_o, .busy_o);

  // Input stays broken: only a test pulse may reveal it
  cvseq_sensor_model model (.test_current_i(test_current_o),
    .autorange_test_i(autorange_test_o), .broken_i(1'b1), .range_i(3'h5),
    .value_i(24'hffff9c), .open_sense_o(open_sense_i), .range_code_o(range_code_i),
    .adc_result_o(adc_result_i));

  // ============================================================
  // Monitor, sampled mid-cycle where outputs are settled
  always @(negedge clk_i) begin
    if (busy_o === 1'b1) begin
      busy_cnt++;
      seen_tc |= test_current_o;
      seen_ar |= autorange_test_o;
      if (current_ratio_o > max_ratio) max_ratio = current_ratio_o;
    end
  end

  // ============================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    // Waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) chk(0, 1, "bus hang");
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task run(input logic [5:0] cfg);
    bus(1'b1, 8'h04, {26'h0, cfg});
    busy_cnt = 0;
    seen_tc = 1'b0;
    seen_ar = 1'b0;
    max_ratio = 2'h0;
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h00, 32'h1);
    nc = 0;
    while (busy_o !== 1'b0 && nc < 200) begin
      @(negedge clk_i);
      nc++;
    end
    if (nc >= 200) chk(0, 1, "result hang");
  endtask : run

  task end_of_test;
    $display("Summary: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ============================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b1, 8'h1c, 32'h3);
    for (int i = 0; i < 8; i++) begin
      run(cfgs[i]);
      chk(busy_cnt, ((i < 4) ? 2 : 3) * CC, "cycle count");
      chk(seen_tc, i == 4, "test current");
      chk(seen_ar, i == 6, "range test");
      chk(max_ratio, (i == 7) ? 3 : 0, "diode ratios");
      if (i == 6) chk(excite_range_o, 3'h5, "chosen range");
      chk(irq_o, 1'b1, "irq raised");
      bus(1'b0, 8'h08, 32'h0);
      chk(rd[2:1], {i == 4, 1'b1}, "fault and done");
      chk(rd[6:5], (i < 4) ? 2'h2 : 2'h3, "cycle total");
      bus(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'hffffff9c, "signed result");
      bus(1'b0, 8'h18, 32'h0);
      chk(rd[1:0], {i == 4, 1'b1}, "irq status");
      @(negedge clk_i);
      chk(irq_o, 1'b0, "irq cleared");
      $display("Test mode %0d done", i);
    end
    // Zero field not clear: not a table lookup word
    bus(1'b1, 8'h10, 32'hf2001089);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[3], 1'b0, "bad word");
    bus(1'b1, 8'h10, 32'hf6000089);
    bus(1'b0, 8'h08, 32'h0);
    // Table mode is latched only when a result starts
    chk(rd[4:3], 2'h1, "table word");
    bus(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h8025c089, "table info");
    bus(1'b1, 8'h1c, 32'h0);
    run(6'h04);
    chk(busy_cnt, 2 * CC, "table cycles");
    chk(seen_tc, 1'b0, "no test in table");
    chk(irq_o, 1'b0, "irq masked");
    bus(1'b0, 8'h18, 32'h0);
    chk(rd[0], 1'b1, "sticky done");
    bus(1'b0, 8'h08, 32'h0);
    chk(rd[6:3], 4'hb, "table status");
    $display("Test table done");
    end_of_test();
  end

  // Whole run is some 600 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    $display("FAIL %0t watchdog expired", $time);
    n_fail++;
    end_of_test();
  end
endmodule : cvseq_tb_top
